// ===== design/serial_shifter_pkg.sv
// shared constants of the dual-use output port and serial shifter
package serial_shifter_pkg;

    // ---------------------------------------------
    // widths
    // ---------------------------------------------
    localparam int NIB_W = 4;
    localparam int BYTE_W = 8;
    localparam int FLAG_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int DIV_W = 8;
    localparam int BITCNT_W = 3;

    // ---------------------------------------------
    // port mode register two fields
    // ---------------------------------------------
    localparam int PM_SERIAL_BIT = 1;
    localparam int PM_RATE_BIT = 3;
    localparam logic [3:0] PM_RESET = 4'h0;

    // ---------------------------------------------
    // serial status fields
    // ---------------------------------------------
    localparam int ST_RX_BUSY_BIT = 1;
    localparam int ST_TX_BUSY_BIT = 3;
    localparam logic [3:0] STATUS_RESET = 4'h0;

    // ---------------------------------------------
    // event, interrupt and hold release bits
    // ---------------------------------------------
    localparam int EV_RX_BIT = 5;
    localparam int EV_TX_BIT = 6;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // ---------------------------------------------
    // pin positions on the dual-use port
    // ---------------------------------------------
    localparam int PIN_DOUT = 0;
    localparam int PIN_TXCLK = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_RXCLK = 3;
    localparam logic [3:0] LATCH_RESET = 4'hF;

    // ---------------------------------------------
    // shift clock timing, in system clock cycles
    // ---------------------------------------------
    localparam int FAST_DIV = 2;
    localparam int SLOW_DIV = 256;
    localparam logic [DIV_W-1:0] HALF_FAST = DIV_W'(FAST_DIV / 2 - 1);
    localparam logic [DIV_W-1:0] HALF_SLOW = DIV_W'(SLOW_DIV / 2 - 1);
    localparam logic [BITCNT_W-1:0] LAST_BIT = 3'h7;

    typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} shift_state_t;

endpackage

// ===== design/small_fifo.sv
// small synchronous fifo with registered full and empty
`timescale 1ns/1ps
module small_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic [PW:0] count_nxt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_ptr_r];

    always_comb
    begin
        count_nxt = count_r;
        if (push && !pop)
            count_nxt = count_r + (PW+1)'(1);
        else if (pop && !push)
            count_nxt = count_r - (PW+1)'(1);
    end

    always_ff @(posedge clk)
    begin
        if (clk_en && push)
            mem_r[wr_ptr_r] <= in_data;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
            if (pop)
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
            count_r <= count_nxt;
            in_ready <= (count_nxt != FULL_CNT);
            out_valid <= (count_nxt != '0);
        end
    end
endmodule

// ===== design/output_port_serial_shifter.sv
// dual-use output port: parallel latch or 8-bit synchronous serial port
`timescale 1ns/1ps
module output_port_serial_shifter
    import serial_shifter_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // core instructions
    input wire logic port_mode_wr,
    input wire logic [serial_shifter_pkg::NIB_W-1:0] port_mode_wdata,
    input wire logic par_write,
    input wire logic [serial_shifter_pkg::NIB_W-1:0] par_write_data,
    input wire logic recv_instr,
    output logic [serial_shifter_pkg::NIB_W-1:0] recv_acc_r,
    output logic [serial_shifter_pkg::NIB_W-1:0] recv_ram_r,
    output logic recv_valid_r,
    input wire logic send_instr,
    input wire logic [serial_shifter_pkg::NIB_W-1:0] send_acc,
    input wire logic [serial_shifter_pkg::NIB_W-1:0] send_ram,
    output logic send_ready,
    input wire logic status_clear,
    output logic [serial_shifter_pkg::NIB_W-1:0] serial_status_r,
    // interrupt and hold control
    input wire logic int_mask_wr,
    input wire logic [serial_shifter_pkg::FLAG_W-1:0] int_mask_wdata,
    input wire logic hold_en_wr,
    input wire logic [serial_shifter_pkg::FLAG_W-1:0] hold_en_wdata,
    input wire logic int_enable_instr,
    input wire logic int_disable_instr,
    input wire logic event_clear,
    input wire logic [serial_shifter_pkg::FLAG_W-1:0] event_clear_mask,
    input wire logic int_ack,
    output logic [serial_shifter_pkg::FLAG_W-1:0] event_flags_r,
    output logic irq_r,
    output logic [serial_shifter_pkg::FLAG_W-1:0] irq_source_r,
    output logic hold_release_r,
    // dual-use output port pins
    input wire logic din_pin,
    output logic [serial_shifter_pkg::NIB_W-1:0] port_out_r,
    output logic [serial_shifter_pkg::NIB_W-1:0] port_oe_r
);
    import serial_shifter_pkg::*;

    // ---------------------------------------------
    // declarations
    // ---------------------------------------------
    logic [3:0] port_mode_r;
    logic [NIB_W-1:0] latch_r;
    logic [FLAG_W-1:0] int_mask_r;
    logic [FLAG_W-1:0] hold_en_r;
    logic int_allow_r;
    logic din_meta_r;
    logic din_sync_r;
    logic serial_mode;
    logic [DIV_W-1:0] half_cnt;

    shift_state_t tx_state_r;
    logic [DIV_W-1:0] tx_div_r;
    logic [BITCNT_W-1:0] tx_bit_r;
    logic [BYTE_W-1:0] sob_r;
    logic tx_clk_r;
    logic dout_r;
    logic tx_done;

    shift_state_t rx_state_r;
    logic [DIV_W-1:0] rx_div_r;
    logic [BITCNT_W-1:0] rx_bit_r;
    logic [BYTE_W-1:0] sib_r;
    logic rx_clk_r;
    logic rx_done;

    logic fifo_valid;
    logic fifo_pop;
    logic [BYTE_W-1:0] fifo_data;
    logic [FLAG_W-1:0] ev_set;
    logic [FLAG_W-1:0] ev_nxt;
    logic [FLAG_W-1:0] pending;
    logic [FLAG_W-1:0] pick;

    assign serial_mode = port_mode_r[PM_SERIAL_BIT];
    assign half_cnt = port_mode_r[PM_RATE_BIT] ? HALF_SLOW : HALF_FAST;

    // ---------------------------------------------
    // mode register and parallel latch
    // ---------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            port_mode_r <= PM_RESET;
        else if (clk_en && port_mode_wr)
            port_mode_r <= port_mode_wdata;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            latch_r <= LATCH_RESET;
        else if (clk_en && par_write)
            latch_r <= par_write_data;
    end

    // ---------------------------------------------
    // data in synchroniser
    // ---------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            din_meta_r <= 1'b1;
            din_sync_r <= 1'b1;
        end
        else if (clk_en)
        begin
            din_meta_r <= din_pin;
            din_sync_r <= din_meta_r;
        end
    end

    // ---------------------------------------------
    // transmit queue
    // ---------------------------------------------
    small_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(send_instr),
        .in_ready(send_ready),
        .in_data({send_ram, send_acc}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    assign fifo_pop = (tx_state_r == SH_IDLE) && serial_mode;

    // ---------------------------------------------
    // transmit shifter
    // ---------------------------------------------
    assign tx_done = (tx_state_r == SH_HIGH) && (tx_div_r == '0) && (tx_bit_r == LAST_BIT);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_state_r <= SH_IDLE;
            tx_div_r <= '0;
            tx_bit_r <= '0;
            sob_r <= '0;
            tx_clk_r <= 1'b1;
            dout_r <= 1'b1;
        end
        else if (clk_en)
        begin
            unique case (tx_state_r)
                SH_IDLE:
                begin
                    if (fifo_valid && serial_mode)
                    begin
                        sob_r <= fifo_data >> 1;
                        dout_r <= fifo_data[0];
                        tx_clk_r <= 1'b0;
                        tx_div_r <= half_cnt;
                        tx_bit_r <= '0;
                        tx_state_r <= SH_LOW;
                    end
                end
                SH_LOW:
                begin
                    if (tx_div_r == '0)
                    begin
                        tx_clk_r <= 1'b1;
                        tx_div_r <= half_cnt;
                        tx_state_r <= SH_HIGH;
                    end
                    else
                        tx_div_r <= tx_div_r - DIV_W'(1);
                end
                SH_HIGH:
                begin
                    if (tx_div_r != '0)
                        tx_div_r <= tx_div_r - DIV_W'(1);
                    else if (tx_bit_r == LAST_BIT)
                        tx_state_r <= SH_IDLE;
                    else
                    begin
                        dout_r <= sob_r[0];
                        sob_r <= sob_r >> 1;
                        tx_clk_r <= 1'b0;
                        tx_div_r <= half_cnt;
                        tx_bit_r <= tx_bit_r + BITCNT_W'(1);
                        tx_state_r <= SH_LOW;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------
    // receive shifter
    // ---------------------------------------------
    assign rx_done = (rx_state_r == SH_HIGH) && (rx_div_r == '0) && (rx_bit_r == LAST_BIT);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_state_r <= SH_IDLE;
            rx_div_r <= '0;
            rx_bit_r <= '0;
            sib_r <= '0;
            rx_clk_r <= 1'b1;
        end
        else if (clk_en)
        begin
            if (recv_instr && serial_mode)
            begin
                rx_clk_r <= 1'b0;
                rx_div_r <= half_cnt;
                rx_bit_r <= '0;
                rx_state_r <= SH_LOW;
            end
            else
            begin
                unique case (rx_state_r)
                    SH_IDLE:
                        rx_clk_r <= 1'b1;
                    SH_LOW:
                    begin
                        if (rx_div_r == '0)
                        begin
                            rx_clk_r <= 1'b1;
                            sib_r <= {din_sync_r, sib_r[BYTE_W-1:1]};
                            rx_div_r <= half_cnt;
                            rx_state_r <= SH_HIGH;
                        end
                        else
                            rx_div_r <= rx_div_r - DIV_W'(1);
                    end
                    SH_HIGH:
                    begin
                        if (rx_div_r != '0)
                            rx_div_r <= rx_div_r - DIV_W'(1);
                        else if (rx_bit_r == LAST_BIT)
                            rx_state_r <= SH_IDLE;
                        else
                        begin
                            rx_clk_r <= 1'b0;
                            rx_div_r <= half_cnt;
                            rx_bit_r <= rx_bit_r + BITCNT_W'(1);
                            rx_state_r <= SH_LOW;
                        end
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------
    // receive instruction answer
    // ---------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            recv_acc_r <= '0;
            recv_ram_r <= '0;
            recv_valid_r <= 1'b0;
        end
        else if (clk_en)
        begin
            recv_valid_r <= recv_instr;
            if (recv_instr)
            begin
                recv_acc_r <= sib_r[NIB_W-1:0];
                recv_ram_r <= sib_r[BYTE_W-1:NIB_W];
            end
        end
    end

    // ---------------------------------------------
    // serial status, set wins over clear
    // ---------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            serial_status_r <= STATUS_RESET;
        else if (clk_en)
        begin
            if (recv_instr && serial_mode)
                serial_status_r[ST_RX_BUSY_BIT] <= 1'b1;
            else if (rx_done || status_clear)
                serial_status_r[ST_RX_BUSY_BIT] <= 1'b0;
            if (send_instr && send_ready)
                serial_status_r[ST_TX_BUSY_BIT] <= 1'b1;
            else if ((tx_done && !fifo_valid) || status_clear)
                serial_status_r[ST_TX_BUSY_BIT] <= 1'b0;
        end
    end

    // ---------------------------------------------
    // event flags, interrupt and hold release
    // ---------------------------------------------
    always_comb
    begin
        ev_set = '0;
        ev_set[EV_RX_BIT] = rx_done;
        ev_set[EV_TX_BIT] = tx_done;
        ev_nxt = event_flags_r;
        if (event_clear)
            ev_nxt = ev_nxt & ~event_clear_mask;
        if (int_ack)
            ev_nxt = ev_nxt & ~irq_source_r;
        ev_nxt = ev_nxt | ev_set;
        pending = event_flags_r & int_mask_r;
        pick = '0;
        if (pending[EV_RX_BIT])
            pick[EV_RX_BIT] = 1'b1;
        else if (pending[EV_TX_BIT])
            pick[EV_TX_BIT] = 1'b1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            event_flags_r <= FLAGS_RESET;
        else if (clk_en)
            event_flags_r <= ev_nxt;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            int_mask_r <= FLAGS_RESET;
            hold_en_r <= FLAGS_RESET;
        end
        else if (clk_en)
        begin
            if (int_mask_wr)
                int_mask_r <= int_mask_wdata;
            if (hold_en_wr)
                hold_en_r <= hold_en_wdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            int_allow_r <= 1'b0;
        else if (clk_en)
        begin
            if (int_ack || int_disable_instr)
                int_allow_r <= 1'b0;
            else if (int_enable_instr || int_mask_wr)
                int_allow_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_r <= 1'b0;
            irq_source_r <= '0;
            hold_release_r <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_r <= int_allow_r && !int_ack && (pick != '0);
            irq_source_r <= pick;
            hold_release_r <= (ev_nxt & hold_en_r) != '0;
        end
    end

    // ---------------------------------------------
    // pin multiplexer
    // ---------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            port_out_r <= LATCH_RESET;
            port_oe_r <= '1;
        end
        else if (clk_en)
        begin
            if (serial_mode)
            begin
                port_out_r[PIN_DOUT] <= dout_r;
                port_out_r[PIN_TXCLK] <= tx_clk_r;
                port_out_r[PIN_DIN] <= 1'b1;
                port_out_r[PIN_RXCLK] <= rx_clk_r;
                port_oe_r <= '1;
                port_oe_r[PIN_DIN] <= 1'b0;
            end
            else
            begin
                port_out_r <= latch_r;
                port_oe_r <= '1;
            end
        end
    end

endmodule

// ===== tb/port_shifter_props.sv
// checker for the dual-use output port and serial shifter
`timescale 1ns/1ps
module port_shifter_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic recv_instr,
    input wire logic recv_valid_r,
    input wire logic send_instr,
    input wire logic send_ready,
    input wire logic [3:0] serial_status_r,
    input wire logic int_mask_wr,
    input wire logic int_enable_instr,
    input wire logic int_ack,
    input wire logic [7:0] event_flags_r,
    input wire logic irq_r,
    input wire logic [7:0] irq_source_r,
    input wire logic hold_release_r,
    input wire logic [3:0] port_out_r,
    input wire logic [3:0] port_oe_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ---------------------------------------------
    // sequences
    // ---------------------------------------------
    sequence s_ack;
        int_ack && irq_r;
    endsequence
    sequence s_quiet;
        (!int_enable_instr && !int_mask_wr)[*4];
    endsequence
    // ---------------------------------------------
    // properties
    // ---------------------------------------------
    a_recv_answer: assert property (clk_en && recv_instr |=> recv_valid_r)
        else $error("receive answer missing");
    a_recv_busy: assert property (clk_en && recv_instr && !port_oe_r[2] |=> serial_status_r[1])
        else $error("receive busy not set");
    a_send_busy: assert property (clk_en && send_instr && send_ready |=> serial_status_r[3])
        else $error("transmit busy not set");
    a_status_rsvd: assert property (!serial_status_r[0] && !serial_status_r[2])
        else $error("reserved status bit set");
    a_rx_event: assert property ($rose(event_flags_r[5]) |-> !serial_status_r[1])
        else $error("receive event while busy");
    a_tx_idle: assert property ($rose(event_flags_r[6]) |-> port_out_r[1])
        else $error("transmit event with clock low");
    a_pins_drive: assert property (port_oe_r[0] && port_oe_r[1] && port_oe_r[3])
        else $error("output pin not driven");
    a_irq_src: assert property ($rose(irq_r) |-> irq_source_r == 8'h20 || irq_source_r == 8'h40)
        else $error("bad interrupt source");
    a_ack_clear: assert property ((s_ack and irq_source_r[5] && !serial_status_r[1])
        |-> ##2 !event_flags_r[5])
        else $error("event not cleared by ack");
    a_ack_keep: assert property ((s_ack and irq_source_r[5] && event_flags_r[6])
        |=> event_flags_r[6])
        else $error("other event lost on ack");
    a_irq_hold: assert property (s_ack ##1 s_quiet |-> !irq_r)
        else $error("interrupt not blocked");
    a_hold_cause: assert property (hold_release_r |-> |event_flags_r[6:5])
        else $error("hold release without event");
endmodule
bind output_port_serial_shifter port_shifter_props chk (.clk, .sys_rst, .clk_en, .recv_instr,
    .recv_valid_r, .send_instr, .send_ready, .serial_status_r, .int_mask_wr, .int_enable_instr,
    .int_ack, .event_flags_r, .irq_r, .irq_source_r, .hold_release_r, .port_out_r, .port_oe_r);

// ===== tb/serial_peer.sv
// model of the serial peripheral clocked by the port
`timescale 1ns/1ps
module serial_peer (
    input wire logic active,
    input wire logic dout_pin,
    input wire logic tx_clk_pin,
    input wire logic rx_clk_pin,
    input wire logic [7:0] send_byte,
    output logic din_pin,
    output logic [7:0] got_byte,
    output int tx_pulses,
    output int rx_pulses
);
    initial
    begin
        din_pin = 1'b1;
        got_byte = 8'h00;
        tx_pulses = 0;
        rx_pulses = 0;
    end
    // next bit shown at receive clock fall
    always @(negedge rx_clk_pin)
    begin
        if (active)
            din_pin <= send_byte[rx_pulses % 8];
    end
    // after eighth rise release to pull-up
    always @(posedge rx_clk_pin)
    begin
        if (active)
        begin
            rx_pulses <= rx_pulses + 1;
            if (rx_pulses % 8 == 7)
                din_pin <= 1'b1;
        end
    end
    // capture on transmit clock rise, lsb first
    always @(posedge tx_clk_pin)
    begin
        if (active)
        begin
            tx_pulses <= tx_pulses + 1;
            got_byte <= {dout_pin, got_byte[7:1]};
        end
    end
endmodule

// ===== tb/output_port_serial_shifter_tb_top.sv
// testbench of the dual-use output port and serial shifter
`timescale 1ns/1ps
module output_port_serial_shifter_tb_top;
    import serial_shifter_pkg::*;
    logic clk, sys_rst, clk_en, port_mode_wr, par_write, recv_instr, send_instr, status_clear;
    logic int_mask_wr, hold_en_wr, int_enable_instr, int_disable_instr, event_clear, int_ack;
    logic recv_valid_r, send_ready, irq_r, hold_release_r, din_pin;
    logic [3:0] port_mode_wdata, par_write_data, send_acc, send_ram, recv_acc_r, recv_ram_r;
    logic [3:0] serial_status_r, port_out_r, port_oe_r;
    logic [7:0] int_mask_wdata, hold_en_wdata, event_clear_mask, event_flags_r, irq_source_r;
    logic [7:0] peer_byte, got_byte;
    int tx_pulses, rx_pulses, bad_count, total_checks;
    output_port_serial_shifter uut (.clk, .sys_rst, .clk_en, .port_mode_wr, .port_mode_wdata,
        .par_write, .par_write_data, .recv_instr, .recv_acc_r, .recv_ram_r, .recv_valid_r,
        .send_instr, .send_acc, .send_ram, .send_ready, .status_clear, .serial_status_r,
        .int_mask_wr, .int_mask_wdata, .hold_en_wr, .hold_en_wdata, .int_enable_instr,
        .int_disable_instr, .event_clear, .event_clear_mask, .int_ack, .event_flags_r, .irq_r,
        .irq_source_r, .hold_release_r, .din_pin, .port_out_r, .port_oe_r);
    serial_peer peer (.active(!port_oe_r[PIN_DIN]), .dout_pin(port_out_r[PIN_DOUT]),
        .tx_clk_pin(port_out_r[PIN_TXCLK]), .rx_clk_pin(port_out_r[PIN_RXCLK]),
        .send_byte(peer_byte), .din_pin, .got_byte, .tx_pulses, .rx_pulses);
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic set_mode(input logic [3:0] v);
        port_mode_wdata = v;
        port_mode_wr = 1'b1;
        tick(1);
        port_mode_wr = 1'b0;
        tick(3);
    endtask
    task automatic wait_idle(input int b, input int lim);
        int n;
        for (n = 0; n < lim && serial_status_r[b] !== 1'b0; n++)
            tick(1);
        chk(8'(n < lim), 8'h01);
        tick(2);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_reset;
        chk(8'(port_out_r), 8'(LATCH_RESET));
        chk(8'(port_oe_r), 8'h0F);
        chk(8'(serial_status_r), 8'(STATUS_RESET));
        chk(event_flags_r, FLAGS_RESET);
        chk(8'({irq_r, send_ready}), 8'h01);
    endtask
    task automatic t_parallel;
        foreach (peer_byte[i])
        begin
            par_write_data = i[0] ? 4'h5 : 4'hA;
            par_write = 1'b1;
            tick(1);
            par_write = 1'b0;
            tick(3);
            chk(8'(port_out_r), 8'(par_write_data));
        end
    endtask
    task automatic t_receive;
        int r0;
        set_mode(4'hA);
        chk(8'(port_oe_r), 8'h0B);
        peer_byte = 8'hC6;
        r0 = rx_pulses;
        recv_instr = 1'b1;
        tick(1);
        recv_instr = 1'b0;
        chk(8'({recv_valid_r, serial_status_r[1]}), 8'h03);
        wait_idle(1, 3000);
        chk(8'(rx_pulses - r0), 8'h08);
        chk(8'(event_flags_r[5]), 8'h01);
        recv_instr = 1'b1;
        tick(1);
        recv_instr = 1'b0;
        chk({recv_ram_r, recv_acc_r}, 8'hC6);
        wait_idle(1, 3000);
    endtask
    task automatic t_transmit;
        int t0;
        set_mode(4'h2);
        t0 = tx_pulses;
        send_acc = 4'hB;
        send_ram = 4'h3;
        send_instr = 1'b1;
        tick(1);
        send_instr = 1'b0;
        chk(8'(serial_status_r[3]), 8'h01);
        wait_idle(3, 300);
        chk(got_byte, 8'h3B);
        chk(8'(tx_pulses - t0), 8'h08);
        chk(8'(event_flags_r[6]), 8'h01);
    endtask
    task automatic t_irq;
        hold_en_wdata = 8'h60;
        hold_en_wr = 1'b1;
        tick(1);
        hold_en_wr = 1'b0;
        int_mask_wdata = 8'h60;
        int_mask_wr = 1'b1;
        tick(1);
        int_mask_wr = 1'b0;
        tick(2);
        chk(8'({irq_r, hold_release_r}), 8'h03);
        chk(irq_source_r, 8'h20);
        int_ack = 1'b1;
        tick(1);
        int_ack = 1'b0;
        tick(6);
        chk(event_flags_r, 8'h40);
        chk(8'(irq_r), 8'h00);
        int_disable_instr = 1'b1;
        tick(1);
        int_disable_instr = 1'b0;
        int_enable_instr = 1'b1;
        tick(1);
        int_enable_instr = 1'b0;
        tick(2);
        chk(8'(irq_r), 8'h01);
        chk(irq_source_r, 8'h40);
        int_ack = 1'b1;
        tick(1);
        int_ack = 1'b0;
        tick(2);
        chk(8'({event_flags_r, hold_release_r}), 8'h00);
        int_mask_wdata = 8'h00;
        int_mask_wr = 1'b1;
        tick(1);
        int_mask_wr = 1'b0;
    endtask
    task automatic t_fifo;
        int t0, n, acc, last;
        set_mode(4'hA);
        t0 = tx_pulses;
        acc = 0;
        send_acc = 4'hA;
        for (n = 0; n < 8; n++)
        begin
            send_ram = 4'(n);
            send_instr = 1'b1;
            if (send_ready === 1'b1)
            begin
                acc++;
                last = n;
            end
            tick(1);
        end
        send_instr = 1'b0;
        chk(8'(acc), 8'(FIFO_DEPTH + 1));
        chk(8'(send_ready), 8'h00);
        status_clear = 1'b1;
        tick(1);
        status_clear = 1'b0;
        chk(8'(serial_status_r), 8'h00);
        for (n = 0; n < 14000 && tx_pulses - t0 < 8 * acc; n++)
            tick(1);
        tick(300);
        chk(8'(tx_pulses - t0), 8'(8 * acc));
        chk(got_byte, {4'(last), 4'hA});
        chk(8'(send_ready), 8'h01);
        event_clear_mask = 8'h60;
        event_clear = 1'b1;
        tick(1);
        event_clear = 1'b0;
        chk(event_flags_r, 8'h00);
    endtask
    // ---------------------------------------------
    // clock, watchdog and main sequence
    // ---------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #400_000;
        bad_count++;
        complete_run;
    end
    initial
    begin
        {port_mode_wr, par_write, recv_instr, send_instr, status_clear, int_mask_wr} = '0;
        {hold_en_wr, int_enable_instr, int_disable_instr, event_clear, int_ack} = '0;
        {port_mode_wdata, par_write_data, send_acc, send_ram} = '0;
        {int_mask_wdata, hold_en_wdata, event_clear_mask, peer_byte} = '0;
        bad_count = 0;
        total_checks = 0;
        clk_en = 1'b1;
        sys_rst = 1'b1;
        tick(4);
        sys_rst = 1'b0;
        tick(1);
        t_reset;
        t_parallel;
        t_receive;
        t_transmit;
        t_irq;
        t_fifo;
        complete_run;
    end
endmodule
